/* design/acs_accumulator_subtract_ops.sv */
// accumulator subtract datapath: memory, memory-destination and immediate
// What this block does
// RULE1 - memory subtract: acc gets acc minus memory byte; memory untouched
// RULE2 - minus_to_memory: memory byte gets acc minus that byte
// RULE3 - immediate subtract: acc gets acc minus instruction constant
// RULE4 - borrow (negative result) clears carry to zero
// RULE5 - no borrow (zero or positive) sets carry to one
// RULE6 - also update overflow, zero, nibble-borrow flags; nothing else
`timescale 1ns/1ps
`default_nettype none
module acs_accumulator_subtract_ops
  import acs_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire acs_op_t           i_op,
  input  wire logic [DATA_W-1:0] i_mem_rdata,
  input  wire logic [DATA_W-1:0] i_imm,
  output logic      [DATA_W-1:0] o_acc,
  output logic      [DATA_W-1:0] o_mem_wdata,
  output logic                   o_mem_we,
  output logic                   o_carry,
  output logic                   o_nibble_borrow_flag,
  output logic                   o_zero,
  output logic                   o_signed_range_flag
);
  logic [DATA_W-1:0] acc_r;
  logic [DATA_W-1:0] mem_wdata_r;
  logic              mem_we_r;
  logic [FLAG_W-1:0] flags_r;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] diff;
  logic              c_nxt;
  logic              ac_nxt;
  logic              z_nxt;
  logic              ov_nxt;
  logic              active;

  // immediate op takes the instruction constant, others the memory byte
  assign operand = (i_op == ACS_OP_IMM_TO_ACC) ? i_imm
                                               : i_mem_rdata; // [RULE3]
  assign active  = (i_op != ACS_OP_NONE);

  acs_subtractor acs_subtractor_inst (
    .i_minuend            (acc_r),
    .i_subtrahend         (operand),
    .o_diff               (diff),
    .o_carry              (c_nxt),
    .o_nibble_borrow_flag (ac_nxt),
    .o_zero               (z_nxt),
    .o_signed_range_flag  (ov_nxt)
  );

  // accumulator destination ops
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      acc_r <= ACC_RST;
    end else if (i_op == ACS_OP_MEM_TO_ACC ||
                 i_op == ACS_OP_IMM_TO_ACC) begin
      acc_r <= diff;                                  // [RULE1] [RULE3]
    end
  end

  // memory write-back; acc is left unchanged here
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      mem_we_r    <= 1'b0;
      mem_wdata_r <= ACC_RST;
    end else begin
      mem_we_r <= (i_op == ACS_OP_MINUS_TO_MEMORY);   // [RULE1] [RULE2]
      if (i_op == ACS_OP_MINUS_TO_MEMORY) begin
        mem_wdata_r <= diff;                          // [RULE2]
      end
    end
  end

  // flags only change on a subtract
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      flags_r <= {FLAG_W{FLAG_RST}};
    end else if (active) begin
      flags_r[FLAG_CARRY] <= c_nxt;                   // [RULE4] [RULE5]
      flags_r[FLAG_NIB]   <= ac_nxt;                  // [RULE6]
      flags_r[FLAG_ZERO]  <= z_nxt;                   // [RULE6]
      flags_r[FLAG_RANGE] <= ov_nxt;                  // [RULE6]
    end
  end

  assign o_acc                = acc_r;
  assign o_mem_wdata          = mem_wdata_r;
  assign o_mem_we             = mem_we_r;
  assign o_carry              = flags_r[FLAG_CARRY];
  assign o_nibble_borrow_flag = flags_r[FLAG_NIB];
  assign o_zero               = flags_r[FLAG_ZERO];
  assign o_signed_range_flag  = flags_r[FLAG_RANGE];

  // signed 9-bit view of the subtract, kept apart from the datapath
  // so the overflow checks do not reuse the subtractor's own formula
  logic signed [DATA_W:0] sdiff_chk;

  assign sdiff_chk = $signed({acc_r[DATA_W-1], acc_r})
                   - $signed({operand[DATA_W-1], operand});

  sequence s_acc_op;
    i_op == ACS_OP_MEM_TO_ACC || i_op == ACS_OP_IMM_TO_ACC;
  endsequence

  sequence s_mem_op;
    i_op == ACS_OP_MINUS_TO_MEMORY;
  endsequence

  sequence s_idle_op;
    i_op == ACS_OP_NONE;
  endsequence

  // borrow out of the full byte, and its absence
  sequence s_borrow;
    active && acc_r < operand;
  endsequence

  sequence s_no_borrow;
    active && acc_r >= operand;
  endsequence

  // borrow out of the low nibble, and its absence
  sequence s_nib_borrow;
    active && acc_r[NIB_W-1:0] < operand[NIB_W-1:0];
  endsequence

  sequence s_nib_clear;
    active && acc_r[NIB_W-1:0] >= operand[NIB_W-1:0];
  endsequence

  // signed result outside the byte range when the top two bits differ
  sequence s_range_out;
    active && (sdiff_chk[DATA_W] != sdiff_chk[DATA_W-1]);
  endsequence

  sequence s_range_in;
    active && (sdiff_chk[DATA_W] == sdiff_chk[DATA_W-1]);
  endsequence

  sequence s_zero_res;
    active && acc_r == operand;
  endsequence

  sequence s_nonzero_res;
    active && acc_r != operand;
  endsequence

  AST_ACC_MEM: assert property (                      // [RULE1]
    @(posedge i_clock) disable iff (i_rst)
    i_op == ACS_OP_MEM_TO_ACC |=>
      o_acc == $past(acc_r) - $past(i_mem_rdata))
    else $error("acc not acc minus memory");

  AST_ACC_MEM_NOWR: assert property (                 // [RULE1]
    @(posedge i_clock) disable iff (i_rst)
    s_acc_op |=> !o_mem_we)
    else $error("memory written on acc destination op");

  AST_MEM_DEST: assert property (                     // [RULE2]
    @(posedge i_clock) disable iff (i_rst)
    s_mem_op |=> o_mem_we &&
      o_mem_wdata == $past(acc_r) - $past(i_mem_rdata) &&
      o_acc == $past(acc_r))
    else $error("memory destination result wrong");

  AST_WE_ONLY_MEM: assert property (                  // [RULE2]
    @(posedge i_clock) disable iff (i_rst)
    i_op != ACS_OP_MINUS_TO_MEMORY |=> !o_mem_we)
    else $error("write strobe without memory destination op");

  // write-back data must stand until the next memory destination op
  AST_WDATA_STANDS: assert property (                 // [RULE2]
    @(posedge i_clock) disable iff (i_rst)
    i_op != ACS_OP_MINUS_TO_MEMORY |=> $stable(o_mem_wdata))
    else $error("write-back data moved without op");

  AST_IMM: assert property (                          // [RULE3]
    @(posedge i_clock) disable iff (i_rst)
    i_op == ACS_OP_IMM_TO_ACC |=>
      o_acc == $past(acc_r) - $past(i_imm))
    else $error("immediate subtract wrong");

  AST_BORROW: assert property (                       // [RULE4]
    @(posedge i_clock) disable iff (i_rst)
    s_borrow |=> !o_carry)
    else $error("carry not cleared on borrow");

  AST_NOBORROW: assert property (                     // [RULE5]
    @(posedge i_clock) disable iff (i_rst)
    s_no_borrow |=> o_carry)
    else $error("carry not set without borrow");

  AST_ZERO: assert property (                         // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_zero_res |=> o_zero)
    else $error("zero flag not set");

  AST_NONZERO: assert property (                      // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_nonzero_res |=> !o_zero)
    else $error("zero flag set on nonzero result");

  AST_NIB_BORROW: assert property (                   // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_nib_borrow |=> !o_nibble_borrow_flag)
    else $error("nibble flag not cleared on low borrow");

  AST_NIB_CLEAR: assert property (                    // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_nib_clear |=> o_nibble_borrow_flag)
    else $error("nibble flag not set without low borrow");

  AST_RANGE_OUT: assert property (                    // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_range_out |=> o_signed_range_flag)
    else $error("signed range flag not set on overflow");

  AST_RANGE_IN: assert property (                     // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_range_in |=> !o_signed_range_flag)
    else $error("signed range flag set without overflow");

  AST_HOLD: assert property (                         // [RULE6]
    @(posedge i_clock) disable iff (i_rst)
    s_idle_op |=> $stable(flags_r) && $stable(acc_r))
    else $error("state changed without subtract");

  // no disable here: this one watches the reset itself
  AST_RST: assert property (                          // [RULE6]
    @(posedge i_clock)
    i_rst |=> o_acc == ACC_RST && !o_mem_we && o_mem_wdata == ACC_RST &&
      flags_r == {FLAG_W{FLAG_RST}})
    else $error("reset values wrong");
endmodule : acs_accumulator_subtract_ops
`default_nettype wire

/* design/acs_pkg.sv */
// constants and types for the accumulator subtract datapath
package acs_pkg;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned NIB_W      = 4;
  localparam logic [7:0]  ACC_RST    = 8'h00;
  localparam logic        FLAG_RST   = 1'b0;
  // flag vector bit positions
  localparam int unsigned FLAG_CARRY = 0;
  localparam int unsigned FLAG_NIB   = 1;
  localparam int unsigned FLAG_ZERO  = 2;
  localparam int unsigned FLAG_RANGE = 3;
  localparam int unsigned FLAG_W     = 4;

  typedef enum logic [1:0] {
    ACS_OP_NONE,
    ACS_OP_MEM_TO_ACC,
    ACS_OP_MINUS_TO_MEMORY,
    ACS_OP_IMM_TO_ACC
  } acs_op_t;
endpackage : acs_pkg

/* design/acs_subtractor.sv */
// combinational 8-bit subtractor with status flag outputs
`timescale 1ns/1ps
`default_nettype none
module acs_subtractor
  import acs_pkg::*;
(
  input  wire logic [DATA_W-1:0] i_minuend,
  input  wire logic [DATA_W-1:0] i_subtrahend,
  output logic      [DATA_W-1:0] o_diff,
  output logic                   o_carry,
  output logic                   o_nibble_borrow_flag,
  output logic                   o_zero,
  output logic                   o_signed_range_flag
);
  logic [DATA_W:0] wide;
  logic [NIB_W:0]  low;

  // carry is the inverted borrow of the full-width subtract
  assign wide    = {1'b0, i_minuend} - {1'b0, i_subtrahend};
  assign low     = {1'b0, i_minuend[NIB_W-1:0]}
                 - {1'b0, i_subtrahend[NIB_W-1:0]};
  assign o_diff  = wide[DATA_W-1:0];
  assign o_carry = ~wide[DATA_W];                     // [RULE4] [RULE5]
  assign o_nibble_borrow_flag = ~low[NIB_W];          // [RULE6]
  assign o_zero  = (wide[DATA_W-1:0] == 8'h00);       // [RULE6]
  // signs differ and result sign differs from minuend
  assign o_signed_range_flag =
    (i_minuend[DATA_W-1] ^ i_subtrahend[DATA_W-1]) &
    (i_minuend[DATA_W-1] ^ wide[DATA_W-1]);           // [RULE6]
endmodule : acs_subtractor
`default_nettype wire

/* tb/acs_accumulator_subtract_ops_tb.sv */
// self-checking bench for the accumulator subtract datapath
`timescale 1ns/1ps
`default_nettype none
module acs_accumulator_subtract_ops_tb;
  import acs_pkg::*;
  logic       clk = 0, rst = 1, ld = 0, we, cy, nb, zf, of;
  acs_op_t    op = ACS_OP_NONE;
  logic [7:0] ldd = 8'h00, imm = 8'h00, rd, acc, wd, ea = 8'h00, lw = 8'h00;
  int         failures = 0, total_checks = 0, cyc = 0;
  acs_accumulator_subtract_ops acs_accumulator_subtract_ops_inst (
    .i_clock(clk), .i_rst(rst), .i_op(op), .i_mem_rdata(rd),
    .i_imm(imm), .o_acc(acc), .o_mem_wdata(wd), .o_mem_we(we),
    .o_carry(cy), .o_nibble_borrow_flag(nb), .o_zero(zf),
    .o_signed_range_flag(of));
  acs_mem_model acs_mem_model_inst (
    .i_clock(clk), .i_load(ld), .i_load_data(ldd), .i_we(we),
    .i_wdata(wd), .o_rdata(rd));
  always #4 clk = ~clk;
  task automatic tally_and_finish();
    if (failures == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard: the whole run needs well under 100 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 400) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h saw %h", n, e, s);
    end
  endtask : chk
  // one op: operand preloaded into memory and immediate alike
  task automatic run(acs_op_t o, logic [7:0] v);
    logic [7:0] d;
    logic [7:0] f;
    logic       m;
    d = ea - v;
    m = (o == ACS_OP_MINUS_TO_MEMORY);
    f = {5'h00, ea[3:0] >= v[3:0], d == 8'h00, 1'b0};
    f[0] = (ea[7] != v[7]) && (d[7] != ea[7]);
    ld = 1;
    ldd = v;
    imm = v;
    @(negedge clk);
    ld = 0;
    op = o;
    @(negedge clk);
    op = ACS_OP_NONE;
    chk("acc", acc, m ? ea : d);
    chk("we", {7'h00, we}, {7'h00, m});
    chk("wdata", wd, m ? d : lw);
    chk("carry", {7'h00, cy}, {7'h00, ea >= v});
    chk("flags", {5'h00, nb, zf, of}, f);
    @(negedge clk);
    chk("we_low", {7'h00, we}, 8'h00);
    chk("mem", rd, m ? d : v);
    if (m) lw = d;
    else ea = d;
  endtask : run
  // borrow from zero, then write-back leaving acc alone
  task automatic sc_borrow_chain();
    run(ACS_OP_MEM_TO_ACC, 8'h01);
    run(ACS_OP_MINUS_TO_MEMORY, 8'h7F);
    run(ACS_OP_IMM_TO_ACC, 8'h7F);
  endtask : sc_borrow_chain
  // signed overflow with nibble borrow, then an exact zero
  task automatic sc_overflow_zero();
    run(ACS_OP_IMM_TO_ACC, 8'h01);
    run(ACS_OP_MEM_TO_ACC, 8'h7F);
    run(ACS_OP_MINUS_TO_MEMORY, 8'h80);
  endtask : sc_overflow_zero
  // reset in mid-run clears acc, flags and write-back state
  task automatic sc_mid_reset();
    run(ACS_OP_IMM_TO_ACC, 8'h80);
    rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    @(negedge clk);
    chk("acc_rst2", acc, ACC_RST);
    chk("flags_rst", {4'h0, cy, nb, zf, of}, 8'h00);
    chk("we_rst", {7'h00, we}, 8'h00);
    chk("wdata_rst", wd, 8'h00);
    ea = 8'h00;
    lw = 8'h00;
  endtask : sc_mid_reset
  // two ops on consecutive edges with acc forwarded, then an idle cycle
  task automatic sc_back_to_back();
    imm = 8'h03;
    op = ACS_OP_IMM_TO_ACC;
    @(negedge clk);
    imm = 8'h02;
    @(negedge clk);
    op = ACS_OP_NONE;
    chk("acc_b2b", acc, 8'hFB);
    chk("carry_b2b", {7'h00, cy}, 8'h01);
    chk("flags_b2b", {5'h00, nb, zf, of}, 8'h04);
    @(negedge clk);
    chk("acc_idle", acc, 8'hFB);
    chk("flags_idle", {4'h0, cy, nb, zf, of}, 8'h0C);
    ea = 8'hFB;
  endtask : sc_back_to_back
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    chk("acc_rst", acc, ACC_RST);
    sc_borrow_chain();
    sc_overflow_zero();
    sc_mid_reset();
    sc_back_to_back();
    tally_and_finish();
  end
endmodule : acs_accumulator_subtract_ops_tb
`default_nettype wire

/* tb/acs_mem_model.sv */
// data memory byte model facing the subtract datapath
`timescale 1ns/1ps
`default_nettype none
module acs_mem_model
  import acs_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_load,
  input  wire logic [DATA_W-1:0] i_load_data,
  input  wire logic              i_we,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata
);
  // write lands a cycle late, on the edge after the core raises i_we
  always_ff @(posedge i_clock) begin
    if (i_load) begin
      o_rdata <= i_load_data;
    end else if (i_we) begin
      o_rdata <= i_wdata;
    end
  end
endmodule : acs_mem_model
`default_nettype wire
